// file: shared/sas_map.svh
// register map, bit positions and reset value of the slave access status
// assumes big-endian bit index 31..0 (word bit 0 is index 31)
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH

// register bus byte offset
`define SAS_REG_OFFSET   20'h1D220
// peripheral address window seen by the external master
`define SAS_PADDR_FIRST  8'h20
`define SAS_PADDR_LAST   8'h23
// flag positions as vector indices
`define SAS_ACCESS_OK_IDX 7
`define SAS_OMB_IDX      3
`define SAS_IMB_IDX      2
`define SAS_ALERT_IDX    0
// implemented bits, all others read zero
`define SAS_IMPL_MASK    32'h0000008D
`define SAS_RESET_VAL    32'h00000000
// idle value of the slave byte answer
`define SAS_BYTE_RESET   8'h00

`endif

// file: shared/sas_pkg.sv
// types shared by the slave access status block
// assumes sas_map.svh supplies the numeric map
package sas_pkg;

  typedef logic [31:0] sas_word_t;
  typedef logic [7:0]  sas_byte_t;
  typedef logic [19:0] sas_addr_t;

endpackage

// file: verilog/sas_sync.sv
// two-flop synchroniser, one per bit
// assumes inputs are asynchronous to clk_i
`timescale 1ns/1ps

module sas_sync #(
  parameter int W = 2
) (
  input  wire logic         clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      logic meta_r;
      logic sync_r;
      always_ff @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          meta_r <= 1'b1;
          sync_r <= 1'b1;
        end
        else
        begin
          meta_r <= async_i[gi];
          sync_r <= meta_r;
        end
      end
      assign sync_o[gi] = sync_r;
    end
  endgenerate

endmodule // sas_sync

// file: verilog/sas_status.sv
// slave access status word: flags, register bus read, slave byte read
// assumes event inputs are one-cycle pulses on core_clk_i; bus pins async
`timescale 1ns/1ps
`include "sas_map.svh"

// Contract
// - status word is read-only from register bus and slave interface
// - word bytes map to peripheral addresses 0x20 to 0x23
// - dedicated bus reset clears the whole word to zero
// - flags at bits 24, 28, 29 (31 alert); other bits read zero
// - access-ok sets when a slave-initiated internal access succeeds
// - master read of address 0x20 returns access-ok then clears it
// - register bus and indirect reads leave access-ok unchanged
// - software write of outgoing mailbox sets outgoing flag
// - outgoing flag stays set until master has read the mailbox
// - completed outgoing mailbox read pulses the drained interrupt
// - mailbox access completes only at the master's STOP condition
// - master write sets incoming flag, software read clears, loaded irq
// - alert flag sets when alert condition rises and right after hard reset
// - alert flag clears on alert response or when condition drops
module sas_status (
  input  wire logic               core_clk_i,
  input  wire logic               nrst_i,
  input  wire logic               i2c_rst_i,
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  input  wire logic               host_rd_i,
  input  wire sas_pkg::sas_addr_t host_addr_i,
  input  wire logic               slv_rd_i,
  input  wire sas_pkg::sas_byte_t slv_paddr_i,
  input  wire logic               acc_done_i,
  input  wire logic               sw_omb_wr_i,
  input  wire logic               slv_omb_rd_i,
  input  wire logic               slv_imb_wr_i,
  input  wire logic               sw_imb_rd_i,
  input  wire logic               alert_cond_i,
  input  wire logic               alert_ack_i,
  input  wire logic               hard_rst_i,
  output sas_pkg::sas_word_t      host_rdata_o,
  output logic                    host_ack_o,
  output sas_pkg::sas_byte_t      slv_rdata_o,
  output logic                    slv_ack_o,
  output sas_pkg::sas_word_t      status_o,
  output logic                    outgoing_mailbox_drained_irq_o,
  output logic                    incoming_mailbox_loaded_irq_o
);

  // ==========================================================
  // declarations
  logic               internal_access_success_flag_r;
  logic               outgoing_mailbox_flag_r;
  logic               incoming_mailbox_flag_r;
  logic               alert_flag_r;
  logic               omb_rd_pend_r;
  logic               imb_wr_pend_r;
  logic               alert_cond_r;
  logic               sda_prev_r;
  logic [1:0]         pins_s;
  logic               scl_s;
  logic               sda_s;
  logic               stop_w;
  logic               slv_hit_w;
  logic               acc_clr_w;
  logic               host_hit_w;
  sas_pkg::sas_word_t stat_w;

  default clocking cb_core @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // ==========================================================
  // pin synchronisation and STOP detection
  sas_sync #(
    .W (2)
  ) u_sync (
    .clk_i   (core_clk_i),
    .nrst_i  (nrst_i),
    .async_i ({scl_i, sda_i}),
    .sync_o  (pins_s)
  );

  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      sda_prev_r <= 1'b1;
    else
      sda_prev_r <= sda_s;
  end

  // sda rising while scl high
  assign stop_w = scl_s & sda_s & ~sda_prev_r;

  // ==========================================================
  // status word assembly and decode
  always_comb
  begin
    stat_w                     = `SAS_RESET_VAL;
    stat_w[`SAS_ACCESS_OK_IDX] = internal_access_success_flag_r;
    stat_w[`SAS_OMB_IDX]       = outgoing_mailbox_flag_r;
    stat_w[`SAS_IMB_IDX]       = incoming_mailbox_flag_r;
    stat_w[`SAS_ALERT_IDX]     = alert_flag_r;
  end

  assign status_o = stat_w;

  // only reads decode; writes have no path into the word
  assign slv_hit_w  = slv_rd_i && (slv_paddr_i >= `SAS_PADDR_FIRST)
                      && (slv_paddr_i <= `SAS_PADDR_LAST);
  assign acc_clr_w  = slv_rd_i && (slv_paddr_i == `SAS_PADDR_FIRST);
  assign host_hit_w = host_rd_i && (host_addr_i == `SAS_REG_OFFSET);

  // ==========================================================
  // access-ok flag
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      internal_access_success_flag_r <= 1'b0;
    else if (i2c_rst_i)
      internal_access_success_flag_r <= 1'b0;
    else if (acc_done_i)
      internal_access_success_flag_r <= 1'b1;
    else if (acc_clr_w)
      internal_access_success_flag_r <= 1'b0;
  end

  // ==========================================================
  // outgoing mailbox
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      omb_rd_pend_r <= 1'b0;
    else if (i2c_rst_i || stop_w)
      omb_rd_pend_r <= 1'b0;
    else if (slv_omb_rd_i)
      omb_rd_pend_r <= 1'b1;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      outgoing_mailbox_flag_r <= 1'b0;
    else if (i2c_rst_i)
      outgoing_mailbox_flag_r <= 1'b0;
    else if (sw_omb_wr_i)
      outgoing_mailbox_flag_r <= 1'b1;
    else if (stop_w && omb_rd_pend_r)
      outgoing_mailbox_flag_r <= 1'b0;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      outgoing_mailbox_drained_irq_o <= 1'b0;
    else
      outgoing_mailbox_drained_irq_o <= stop_w && omb_rd_pend_r
                                        && !i2c_rst_i;
  end

  // ==========================================================
  // incoming mailbox
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      imb_wr_pend_r <= 1'b0;
    else if (i2c_rst_i || stop_w)
      imb_wr_pend_r <= 1'b0;
    else if (slv_imb_wr_i)
      imb_wr_pend_r <= 1'b1;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      incoming_mailbox_flag_r <= 1'b0;
    else if (i2c_rst_i)
      incoming_mailbox_flag_r <= 1'b0;
    else if (stop_w && imb_wr_pend_r)
      incoming_mailbox_flag_r <= 1'b1;
    else if (sw_imb_rd_i)
      incoming_mailbox_flag_r <= 1'b0;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      incoming_mailbox_loaded_irq_o <= 1'b0;
    else
      incoming_mailbox_loaded_irq_o <= stop_w && imb_wr_pend_r
                                       && !i2c_rst_i;
  end

  // ==========================================================
  // alert flag
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      alert_cond_r <= 1'b0;
    else
      alert_cond_r <= alert_cond_i;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      alert_flag_r <= 1'b0;
    else if (i2c_rst_i)
      alert_flag_r <= 1'b0;
    else if (hard_rst_i)
      alert_flag_r <= 1'b1;
    else if (!alert_cond_i || alert_ack_i)
      alert_flag_r <= 1'b0;
    else if (!alert_cond_r)
      alert_flag_r <= 1'b1;
  end

  // ==========================================================
  // read answers
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      host_ack_o   <= 1'b0;
      host_rdata_o <= `SAS_RESET_VAL;
    end
    else
    begin
      host_ack_o   <= host_hit_w;
      host_rdata_o <= host_hit_w ? stat_w : `SAS_RESET_VAL;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      slv_ack_o   <= 1'b0;
      slv_rdata_o <= `SAS_BYTE_RESET;
    end
    else
    begin
      slv_ack_o   <= slv_hit_w;
      slv_rdata_o <= slv_hit_w ? stat_w[8*slv_paddr_i[1:0] +: 8]
                               : `SAS_BYTE_RESET;
    end
  end

  // ==========================================================
  // assertions
  property p_ro_word;
    host_hit_w |=> host_ack_o && host_rdata_o == $past(stat_w);
  endproperty
  a_ro_word: assert property (p_ro_word)
    else $error("register bus read returned wrong word");
  property p_paddr_map;
    slv_rd_i |=> slv_ack_o == $past(slv_hit_w)
      && (!slv_ack_o || slv_rdata_o ==
          $past(stat_w[8*slv_paddr_i[1:0] +: 8]));
  endproperty
  a_paddr_map: assert property (p_paddr_map)
    else $error("slave byte map wrong");
  property p_i2c_rst;
    i2c_rst_i |=> status_o == `SAS_RESET_VAL;
  endproperty
  a_i2c_rst: assert property (p_i2c_rst)
    else $error("bus reset left status set");
  property p_reserved;
    (status_o & ~`SAS_IMPL_MASK) == `SAS_RESET_VAL;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved status bit set");

  property p_acc_set;
    acc_done_i && !i2c_rst_i |=> status_o[`SAS_ACCESS_OK_IDX];
  endproperty
  a_acc_set: assert property (p_acc_set)
    else $error("access-ok did not set");
  property p_acc_clr;
    acc_clr_w && !acc_done_i |=> !internal_access_success_flag_r
      && slv_rdata_o[`SAS_ACCESS_OK_IDX] ==
         $past(internal_access_success_flag_r);
  endproperty
  a_acc_clr: assert property (p_acc_clr)
    else $error("access-ok read-clear wrong");
  property p_acc_keep;
    host_hit_w && !acc_clr_w && !i2c_rst_i |=>
      internal_access_success_flag_r >=
      $past(internal_access_success_flag_r);
  endproperty
  a_acc_keep: assert property (p_acc_keep)
    else $error("host read changed access-ok");

  property p_omb_set;
    sw_omb_wr_i && !i2c_rst_i |=> outgoing_mailbox_flag_r;
  endproperty
  a_omb_set: assert property (p_omb_set)
    else $error("outgoing flag did not set");
  property p_omb_hold;
    $fell(outgoing_mailbox_flag_r) |->
      $past(i2c_rst_i) || $past(stop_w && omb_rd_pend_r);
  endproperty
  a_omb_hold: assert property (p_omb_hold)
    else $error("outgoing flag cleared early");
  property p_omb_irq;
    stop_w && omb_rd_pend_r && !i2c_rst_i && !sw_omb_wr_i |=>
      outgoing_mailbox_drained_irq_o && !outgoing_mailbox_flag_r;
  endproperty
  a_omb_irq: assert property (p_omb_irq)
    else $error("drained interrupt missing");
  property p_stop_only;
    $rose(incoming_mailbox_flag_r) |-> $past(stop_w);
  endproperty
  a_stop_only: assert property (p_stop_only)
    else $error("incoming flag set without STOP");

  property p_imb_irq;
    incoming_mailbox_loaded_irq_o |-> incoming_mailbox_flag_r;
  endproperty
  a_imb_irq: assert property (p_imb_irq)
    else $error("loaded interrupt without flag");
  property p_alert_hard;
    hard_rst_i && !i2c_rst_i |=> alert_flag_r;
  endproperty
  a_alert_hard: assert property (p_alert_hard)
    else $error("alert not set after hard reset");
  property p_alert_drop;
    (!alert_cond_i || alert_ack_i) && !hard_rst_i |=> !alert_flag_r;
  endproperty
  a_alert_drop: assert property (p_alert_drop)
    else $error("alert flag did not clear");

  c_acc_read: cover property (@(posedge core_clk_i)
    internal_access_success_flag_r && acc_clr_w);
  c_omb_drain: cover property (@(posedge core_clk_i)
    outgoing_mailbox_drained_irq_o);
  c_imb_load: cover property (@(posedge core_clk_i)
    incoming_mailbox_loaded_irq_o);

endmodule // sas_status

// file: verif/sas_i2c_master.sv
// behavioural external bus master: start, nine clocks, stop
// assumes pull-ups, so both lines idle high and the clock stands still
`timescale 1ns/1ps

module sas_i2c_master (
  output logic scl_o,
  output logic sda_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // ==========================================================
  // one frame, 160 ns bus clock only inside the frame
  task automatic frame(input logic [8:0] bits);
    int i;
    begin
      sda_o = 1'b0;
      #80 scl_o = 1'b0;
      for (i = 8; i >= 0; i--)
      begin
        sda_o = bits[i];
        #40 scl_o = 1'b1;
        #80 scl_o = 1'b0;
        #40;
      end
      sda_o = 1'b0;
      #80 scl_o = 1'b1;
      #80 sda_o = 1'b1;
    end
  endtask
endmodule // sas_i2c_master

// file: verif/test_sas_status.sv
// self-checking bench for the slave access status word
// assumes sas_map.svh on the include path, sas_i2c_master as far side
`timescale 1ns/1ps
`include "sas_map.svh"

module test_sas_status;
  logic               core_clk_i  = 1'b0;
  logic               nrst_i      = 1'b0;
  logic               host_rd     = 1'b0;
  logic               slv_rd      = 1'b0;
  logic               cond        = 1'b0;
  logic [7:0]         ev          = '0;
  sas_pkg::sas_addr_t haddr       = '0;
  sas_pkg::sas_byte_t paddr       = '0;
  sas_pkg::sas_byte_t p;
  sas_pkg::sas_word_t hdata;
  sas_pkg::sas_word_t status;
  sas_pkg::sas_byte_t sdata;
  logic               hack;
  logic               sack;
  logic               dirq;
  logic               lirq;
  wire logic          scl;
  wire logic          sda;
  sas_pkg::sas_word_t hq[$];
  sas_pkg::sas_byte_t sq[$];
  int                 error_cnt   = 0;
  int                 comparisons = 0;
  int                 seed        = 68859;
  int                 i;

  always #10 core_clk_i = ~core_clk_i;

  // ev: 0 bus reset, 1 acc done, 2 omb wr, 3 omb rd, 4 imb wr,
  // 5 imb rd, 6 alert ack, 7 hard reset
  sas_status DUT (
    .core_clk_i                     (core_clk_i),
    .nrst_i                         (nrst_i),
    .i2c_rst_i                      (ev[0]),
    .scl_i                          (scl),
    .sda_i                          (sda),
    .host_rd_i                      (host_rd),
    .host_addr_i                    (haddr),
    .slv_rd_i                       (slv_rd),
    .slv_paddr_i                    (paddr),
    .acc_done_i                     (ev[1]),
    .sw_omb_wr_i                    (ev[2]),
    .slv_omb_rd_i                   (ev[3]),
    .slv_imb_wr_i                   (ev[4]),
    .sw_imb_rd_i                    (ev[5]),
    .alert_cond_i                   (cond),
    .alert_ack_i                    (ev[6]),
    .hard_rst_i                     (ev[7]),
    .host_rdata_o                   (hdata),
    .host_ack_o                     (hack),
    .slv_rdata_o                    (sdata),
    .slv_ack_o                      (sack),
    .status_o                       (status),
    .outgoing_mailbox_drained_irq_o (dirq),
    .incoming_mailbox_loaded_irq_o  (lirq)
  );

  sas_i2c_master m (
    .scl_o (scl),
    .sda_o (sda)
  );

  // ==========================================================
  // helpers
  task automatic chk(input sas_pkg::sas_word_t got, exp,
                     input string nm);
    begin
      comparisons++;
      if (got !== exp)
      begin
        error_cnt++;
        $display("[FAIL] %s exp %h got %h", nm, exp, got);
      end
    end
  endtask

  task automatic finish_test();
    begin
      if (error_cnt == 0 && comparisons > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask

  // pulse one event, then let the flag update land
  task automatic pulse(input int b);
    begin
      @(negedge core_clk_i) ev[b] = 1'b1;
      @(negedge core_clk_i) ev = '0;
      @(negedge core_clk_i);
    end
  endtask

  task automatic hrd(input sas_pkg::sas_addr_t a,
                     input sas_pkg::sas_word_t e, input logic hit);
    begin
      @(negedge core_clk_i);
      haddr = a;
      host_rd = 1'b1;
      if (hit) hq.push_back(e);
      @(negedge core_clk_i) host_rd = 1'b0;
    end
  endtask

  task automatic srd(input sas_pkg::sas_byte_t a,
                     input sas_pkg::sas_byte_t e, input logic hit);
    begin
      @(negedge core_clk_i);
      paddr = a;
      slv_rd = 1'b1;
      if (hit) sq.push_back(e);
      @(negedge core_clk_i) slv_rd = 1'b0;
    end
  endtask

  task automatic wait_irq(input logic w);
    int n;
    begin
      n = 0;
      while ((w ? lirq : dirq) !== 1'b1 && n < 40)
      begin
        @(negedge core_clk_i);
        n++;
      end
      if (n == 40)
      begin
        error_cnt++;
        finish_test();
      end
    end
  endtask

  task automatic settle();
    repeat (2) @(negedge core_clk_i);
  endtask

  // ==========================================================
  // answer watcher: oldest note against each answer
  always @(negedge core_clk_i)
  begin
    if (hack === 1'b1)
    begin
      if (hq.size() == 0) chk(32'h1, 32'h0, "host_ack");
      else chk(hdata, hq.pop_front(), "host_rdata");
    end
    if (sack === 1'b1)
    begin
      if (sq.size() == 0) chk(32'h1, 32'h0, "slv_ack");
      else chk(32'(sdata), 32'(sq.pop_front()), "slv_rdata");
    end
  end

  // ==========================================================
  // main sequence
  initial
  begin
    repeat (12) @(negedge core_clk_i);
    nrst_i = 1'b1;
    @(negedge core_clk_i);
    chk(status, `SAS_RESET_VAL, "status");
    hrd(`SAS_REG_OFFSET, 32'h0, 1'b1);
    pulse(1);
    chk(status, 32'h80, "status");
    hrd(`SAS_REG_OFFSET, 32'h80, 1'b1);
    hrd(`SAS_REG_OFFSET, 32'h80, 1'b1);
    hrd(20'h1D224, 32'h0, 1'b0);
    srd(`SAS_PADDR_FIRST, 8'h80, 1'b1);
    srd(`SAS_PADDR_FIRST, 8'h00, 1'b1);
    chk(status, 32'h0, "status");
    // random byte addresses around the window
    for (i = 0; i < 12; i++)
    begin
      p = 8'h1C + {4'h0, 4'($random(seed))};
      srd(p, 8'h00, p >= 8'h20 && p <= 8'h23);
    end
    pulse(2);
    chk(status, 32'h08, "status");
    pulse(3);
    chk(status, 32'h08, "status");
    m.frame(9'h1A5);
    wait_irq(1'b0);
    chk(32'(dirq), 32'h1, "drained_irq");
    chk(status, 32'h0, "status");
    @(negedge core_clk_i);
    chk(32'(dirq), 32'h0, "drained_irq");
    pulse(4);
    chk(status, 32'h0, "status");
    m.frame(9'h0F0);
    wait_irq(1'b1);
    chk(32'(lirq), 32'h1, "loaded_irq");
    chk(status, 32'h04, "status");
    @(negedge core_clk_i);
    chk(32'(lirq), 32'h0, "loaded_irq");
    pulse(5);
    chk(status, 32'h0, "status");
    cond = 1'b1;
    settle();
    chk(status, 32'h01, "status");
    srd(`SAS_PADDR_FIRST, 8'h01, 1'b1);
    pulse(6);
    chk(status, 32'h0, "status");
    pulse(7);
    chk(status, 32'h01, "status");
    cond = 1'b0;
    settle();
    chk(status, 32'h0, "status");
    cond = 1'b1;
    settle();
    chk(status, 32'h01, "status");
    cond = 1'b0;
    pulse(1);
    pulse(2);
    chk(status, 32'h88, "status");
    pulse(0);
    chk(status, 32'h0, "status");
    settle();
    chk(32'(hq.size() + sq.size()), 32'h0, "pending");
    finish_test();
  end
endmodule // test_sas_status
